// ===== hw/ubg_pkg.sv
// ubg_pkg: constants and carriers of the baud rate generator
// assumes a 32-bit avalon-mm slave port with byte addresses
package ubg_pkg;

  // register byte offsets, one aligned word each
  localparam logic [7:0] OFF_DIV_LOW   = 8'h00;
  localparam logic [7:0] OFF_DIV_HIGH  = 8'h04;
  localparam logic [7:0] OFF_TX_CTRL   = 8'h08;
  localparam logic [7:0] OFF_BAUD_CTRL = 8'h0c;
  localparam logic [7:0] OFF_CNT_LOW   = 8'h10;
  localparam logic [7:0] OFF_CNT_HIGH  = 8'h14;

  // field positions
  localparam int TX_SYNC_BIT = 4;
  localparam int TX_HS_BIT   = 2;
  localparam int BC_CKP_BIT  = 4;
  localparam int BC_WIDE_BIT = 3;

  // values after reset
  localparam logic [7:0] RST_DIV_LOW  = 8'h00;
  localparam logic [7:0] RST_DIV_HIGH = 8'h00;
  localparam logic       RST_CTRL_BIT = 1'b0;

  // prescaler limits: oscillator cycles per divisor step, minus one
  localparam logic [5:0] PRE_LIM_64 = 6'h3f;
  localparam logic [5:0] PRE_LIM_16 = 6'h0f;
  localparam logic [5:0] PRE_LIM_4  = 6'h03;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [7:0]  address;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } ubg_avl_req_t;

  typedef struct packed {
    logic [31:0] readdata;
    logic        waitrequest;
  } ubg_avl_rsp_t;

  typedef struct packed {
    logic sync_mode;
    logic high_speed_select;
    logic clock_polarity_select;
    logic wide_divisor_select;
  } ubg_cfg_t;

endpackage

// ===== hw/ubg_counter.sv
// ubg_counter: up counter with restart and programmable wrap limit
// assumes limit may change at any time; restart wins over step
`timescale 1ns/1ps
`default_nettype none
module ubg_counter #(
  parameter int W = 8
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // control
  input  wire logic         restart,
  input  wire logic         step,
  input  wire logic [W-1:0] limit,
  // status
  output logic      [W-1:0] count,
  output logic              wrap
);

  typedef struct packed {
    logic [W-1:0] cnt;
  } ubg_cnt_state_t;

  ubg_cnt_state_t st_ff;
  ubg_cnt_state_t nxt_st;

  // >= so a lowered limit never leaves the counter running past it
  assign wrap  = step & ~restart & (st_ff.cnt >= limit);
  assign count = st_ff.cnt;

  always_comb begin
    nxt_st = st_ff;
    if (restart) begin
      nxt_st.cnt = '0;
    end else if (wrap) begin
      nxt_st.cnt = '0;
    end else if (step) begin
      nxt_st.cnt = st_ff.cnt + W'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

endmodule
`default_nettype wire

// ===== hw/ubg_avl_slave.sv
// ubg_avl_slave: avalon-mm handshake with one wait state per access
// assumes the master holds its request until waitrequest is low
`timescale 1ns/1ps
`default_nettype none
module ubg_avl_slave (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  // bus side
  input  wire ubg_pkg::ubg_avl_req_t req,
  output ubg_pkg::ubg_avl_rsp_t      rsp,
  // register side
  input  wire logic [31:0]          rd_value,
  output logic                      wr_fire
);

  typedef struct packed {
    logic        ack;
    logic [31:0] rdata;
  } ubg_slv_state_t;

  ubg_slv_state_t st_ff;
  ubg_slv_state_t nxt_st;
  logic           busy;

  assign busy            = req.read | req.write;
  // one driver for the whole response, readdata above waitrequest
  assign rsp             = {st_ff.rdata, busy & ~st_ff.ack};
  assign wr_fire         = req.write & st_ff.ack;

  // read data captured in the wait cycle, so it stands at the accept edge
  always_comb begin
    nxt_st     = st_ff;
    nxt_st.ack = busy & ~st_ff.ack;
    if (req.read && !st_ff.ack) begin
      nxt_st.rdata = rd_value;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

endmodule
`default_nettype wire

// ===== hw/ubg_baud_generator.sv
// ubg_baud_generator: register file and divider of a serial baud generator
// assumes one 200 MHz clock, avalon-mm master, consumers of baud_tick
//
// The Avalon-MM register port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module ubg_baud_generator (
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  // register bus
  input  wire ubg_pkg::ubg_avl_req_t avl_req,
  output ubg_pkg::ubg_avl_rsp_t      avl_rsp,
  // generator outputs
  output logic                       baud_tick,
  output ubg_pkg::ubg_cfg_t          cfg
);

  typedef struct packed {
    logic [7:0]        div_low;
    logic [7:0]        div_high;
    ubg_pkg::ubg_cfg_t cfg;
    logic              tick;
  } ubg_top_state_t;

  ubg_top_state_t st_ff;
  ubg_top_state_t nxt_st;

  logic        wr_fire;
  logic        wr_low;
  logic        wr_high;
  logic        wr_tx;
  logic        wr_bc;
  logic [7:0]  acc_addr;
  logic [31:0] rd_value;
  logic [15:0] divisor_n;
  logic [5:0]  pre_limit;
  logic        restart;
  logic [5:0]  pre_count;
  logic        pre_wrap;
  logic [15:0] div_count;
  logic        div_wrap;

  // word address, byte lane bits ignored
  assign acc_addr = {avl_req.address[7:2], 2'b00};

  ubg_avl_slave u_slave (
    .clk      (clk),
    .rst_n    (rst_n),
    .req      (avl_req),
    .rsp      (avl_rsp),
    .rd_value (rd_value),
    .wr_fire  (wr_fire)
  );

  // registers are 8 bits wide, only lane 0 can write them
  assign wr_low  = wr_fire & avl_req.byteenable[0] & (acc_addr == ubg_pkg::OFF_DIV_LOW);
  assign wr_high = wr_fire & avl_req.byteenable[0] & (acc_addr == ubg_pkg::OFF_DIV_HIGH);
  assign wr_tx   = wr_fire & avl_req.byteenable[0] & (acc_addr == ubg_pkg::OFF_TX_CTRL);
  assign wr_bc   = wr_fire & avl_req.byteenable[0] & (acc_addr == ubg_pkg::OFF_BAUD_CTRL);

  // a divisor byte write starts a fresh period; a wide bit write changes the divisor without restart
  assign restart = wr_low | wr_high;

  // divisor pair, high byte masked in narrow mode
  always_comb begin
    if (st_ff.cfg.wide_divisor_select) begin
      divisor_n = {st_ff.div_high, st_ff.div_low};
    end else begin
      divisor_n = {8'h00, st_ff.div_low};
    end
  end

  // prescale ratio from sync, wide and high speed bits
  always_comb begin
    if (st_ff.cfg.sync_mode) begin
      pre_limit = ubg_pkg::PRE_LIM_4;
    end else if (st_ff.cfg.wide_divisor_select) begin
      if (st_ff.cfg.high_speed_select) begin
        pre_limit = ubg_pkg::PRE_LIM_4;
      end else begin
        pre_limit = ubg_pkg::PRE_LIM_16;
      end
    end else begin
      if (st_ff.cfg.high_speed_select) begin
        pre_limit = ubg_pkg::PRE_LIM_16;
      end else begin
        pre_limit = ubg_pkg::PRE_LIM_64;
      end
    end
  end

  ubg_counter #(
    .W (6)
  ) u_prescale (
    .clk     (clk),
    .rst_n   (rst_n),
    .restart (restart),
    .step    (1'b1),
    .limit   (pre_limit),
    .count   (pre_count),
    .wrap    (pre_wrap)
  );

  ubg_counter #(
    .W (16)
  ) u_divide (
    .clk     (clk),
    .rst_n   (rst_n),
    .restart (restart),
    .step    (pre_wrap),
    .limit   (divisor_n),
    .count   (div_count),
    .wrap    (div_wrap)
  );

  // read mux, unmapped words and unused bits read zero
  always_comb begin
    rd_value = 32'h0000_0000;
    case (acc_addr)
      ubg_pkg::OFF_DIV_LOW: begin
        rd_value[7:0] = st_ff.div_low;
      end
      ubg_pkg::OFF_DIV_HIGH: begin
        rd_value[7:0] = st_ff.div_high;
      end
      ubg_pkg::OFF_TX_CTRL: begin
        rd_value[ubg_pkg::TX_SYNC_BIT] = st_ff.cfg.sync_mode;
        rd_value[ubg_pkg::TX_HS_BIT]   = st_ff.cfg.high_speed_select;
      end
      ubg_pkg::OFF_BAUD_CTRL: begin
        rd_value[ubg_pkg::BC_CKP_BIT]  = st_ff.cfg.clock_polarity_select;
        rd_value[ubg_pkg::BC_WIDE_BIT] = st_ff.cfg.wide_divisor_select;
      end
      ubg_pkg::OFF_CNT_LOW: begin
        rd_value[7:0] = div_count[7:0];
      end
      ubg_pkg::OFF_CNT_HIGH: begin
        rd_value[7:0] = div_count[15:8];
      end
      default: begin
        rd_value = 32'h0000_0000;
      end
    endcase
  end

  always_comb begin
    nxt_st      = st_ff;
    nxt_st.tick = div_wrap;
    if (wr_low) begin
      nxt_st.div_low = avl_req.writedata[7:0];
    end
    if (wr_high) begin
      nxt_st.div_high = avl_req.writedata[7:0];
    end
    if (wr_tx) begin
      nxt_st.cfg.sync_mode         = avl_req.writedata[ubg_pkg::TX_SYNC_BIT];
      nxt_st.cfg.high_speed_select = avl_req.writedata[ubg_pkg::TX_HS_BIT];
    end
    if (wr_bc) begin
      nxt_st.cfg.clock_polarity_select = avl_req.writedata[ubg_pkg::BC_CKP_BIT];
      nxt_st.cfg.wide_divisor_select   = avl_req.writedata[ubg_pkg::BC_WIDE_BIT];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff.div_low                   <= ubg_pkg::RST_DIV_LOW;
      st_ff.div_high                  <= ubg_pkg::RST_DIV_HIGH;
      st_ff.cfg.sync_mode             <= ubg_pkg::RST_CTRL_BIT;
      st_ff.cfg.high_speed_select     <= ubg_pkg::RST_CTRL_BIT;
      st_ff.cfg.clock_polarity_select <= ubg_pkg::RST_CTRL_BIT;
      st_ff.cfg.wide_divisor_select   <= ubg_pkg::RST_CTRL_BIT;
      st_ff.tick                      <= 1'b0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign baud_tick = st_ff.tick;
  assign cfg       = st_ff.cfg;

  // checks

  sequence s_low_write;
    avl_req.write && !avl_rsp.waitrequest && avl_req.byteenable[0]
      && (acc_addr == ubg_pkg::OFF_DIV_LOW);
  endsequence

  sequence s_high_write;
    avl_req.write && !avl_rsp.waitrequest && avl_req.byteenable[0]
      && (acc_addr == ubg_pkg::OFF_DIV_HIGH);
  endsequence

  sequence s_counters_clear;
    (pre_count == 6'h00) && (div_count == 16'h0000);
  endsequence

  a_low_write_restart: assert property (
    @(posedge clk) disable iff (!rst_n)
    s_low_write |=> s_counters_clear ##1 (pre_count == 6'h01))
    else $error("low divisor write did not restart the counter");

  a_high_write_restart: assert property (
    @(posedge clk) disable iff (!rst_n)
    s_high_write |=> s_counters_clear ##1 (pre_count == 6'h01))
    else $error("high divisor write did not restart the counter");

  a_high_byte_store: assert property (
    @(posedge clk) disable iff (!rst_n)
    s_high_write |=> (st_ff.div_high == $past(avl_req.writedata[7:0])))
    else $error("high divisor byte not stored");

  a_pair_forms_n: assert property (
    @(posedge clk) disable iff (!rst_n)
    st_ff.cfg.wide_divisor_select |-> (divisor_n == {st_ff.div_high, st_ff.div_low}))
    else $error("divisor pair not formed from both bytes");

  a_narrow_mask_high: assert property (
    @(posedge clk) disable iff (!rst_n)
    !st_ff.cfg.wide_divisor_select |-> (divisor_n == {8'h00, st_ff.div_low}))
    else $error("high byte leaked into narrow divisor");

  a_async_low_64: assert property (
    @(posedge clk) disable iff (!rst_n)
    (!st_ff.cfg.sync_mode && !st_ff.cfg.wide_divisor_select
      && !st_ff.cfg.high_speed_select) |-> (pre_limit == 6'h3f))
    else $error("async narrow low speed ratio is not 64");

  a_async_wide_16: assert property (
    @(posedge clk) disable iff (!rst_n)
    (!st_ff.cfg.sync_mode && st_ff.cfg.wide_divisor_select
      && !st_ff.cfg.high_speed_select) |-> (pre_limit == 6'h0f))
    else $error("async wide low speed ratio is not 16");

  a_sync_ratio_4: assert property (
    @(posedge clk) disable iff (!rst_n)
    st_ff.cfg.sync_mode |-> (pre_limit == 6'h03))
    else $error("sync ratio is not 4");

  a_async_narrow_hs: assert property (
    @(posedge clk) disable iff (!rst_n)
    (!st_ff.cfg.sync_mode && !st_ff.cfg.wide_divisor_select
      && st_ff.cfg.high_speed_select) |-> (pre_limit == 6'h0f))
    else $error("async narrow high speed ratio is not 16");

  a_async_wide_hs: assert property (
    @(posedge clk) disable iff (!rst_n)
    (!st_ff.cfg.sync_mode && st_ff.cfg.wide_divisor_select
      && st_ff.cfg.high_speed_select) |-> (pre_limit == 6'h03))
    else $error("async wide high speed ratio is not 4");

  a_tx_ctrl_bits: assert property (
    @(posedge clk) disable iff (!rst_n)
    (avl_req.read && !avl_rsp.waitrequest && (acc_addr == ubg_pkg::OFF_TX_CTRL))
      |-> (avl_rsp.readdata[4] == st_ff.cfg.sync_mode)
          && (avl_rsp.readdata[2] == st_ff.cfg.high_speed_select)
          && (avl_rsp.readdata[3] == 1'b0))
    else $error("transmit control bits misplaced");

  a_baud_ctrl_bits: assert property (
    @(posedge clk) disable iff (!rst_n)
    (avl_req.read && !avl_rsp.waitrequest && (acc_addr == ubg_pkg::OFF_BAUD_CTRL))
      |-> (avl_rsp.readdata[3] == st_ff.cfg.wide_divisor_select)
          && (avl_rsp.readdata[4] == st_ff.cfg.clock_polarity_select)
          && (avl_rsp.readdata[2] == 1'b0))
    else $error("baud control bits misplaced");

  a_tick_on_wrap: assert property (
    @(posedge clk) disable iff (!rst_n)
    (pre_wrap && (div_count >= divisor_n) && !restart) |=> baud_tick)
    else $error("tick missing at end of divisor period");

  a_tick_needs_wrap: assert property (
    @(posedge clk) disable iff (!rst_n)
    baud_tick |-> $past(pre_wrap) && ($past(pre_count) == $past(pre_limit)))
    else $error("tick without a finished prescale step");

  a_low_byte_store: assert property (
    @(posedge clk) disable iff (!rst_n)
    s_low_write |=> (st_ff.div_low == $past(avl_req.writedata[7:0])))
    else $error("low divisor byte not stored");

  a_high_byte_holds: assert property (
    @(posedge clk) disable iff (!rst_n)
    !wr_high |=> (st_ff.div_high == $past(st_ff.div_high)))
    else $error("high divisor byte changed without a write");

  a_high_read_back: assert property (
    @(posedge clk) disable iff (!rst_n)
    (avl_req.read && !avl_rsp.waitrequest && (acc_addr == ubg_pkg::OFF_DIV_HIGH))
      |-> (avl_rsp.readdata == {24'h000000, st_ff.div_high}))
    else $error("high divisor byte read back wrong");

  a_one_wait_state: assert property (
    @(posedge clk) disable iff (!rst_n)
    (avl_req.read || avl_req.write) && avl_rsp.waitrequest |=> !avl_rsp.waitrequest)
    else $error("register access not answered after one wait state");

  a_tx_ctrl_store: assert property (
    @(posedge clk) disable iff (!rst_n)
    (avl_req.write && !avl_rsp.waitrequest && avl_req.byteenable[0]
      && (acc_addr == ubg_pkg::OFF_TX_CTRL))
      |=> (st_ff.cfg.sync_mode == $past(avl_req.writedata[ubg_pkg::TX_SYNC_BIT]))
          && (st_ff.cfg.high_speed_select == $past(avl_req.writedata[ubg_pkg::TX_HS_BIT])))
    else $error("transmit control write not stored");

  a_baud_ctrl_store: assert property (
    @(posedge clk) disable iff (!rst_n)
    (avl_req.write && !avl_rsp.waitrequest && avl_req.byteenable[0]
      && (acc_addr == ubg_pkg::OFF_BAUD_CTRL))
      |=> (st_ff.cfg.wide_divisor_select == $past(avl_req.writedata[ubg_pkg::BC_WIDE_BIT]))
          && (st_ff.cfg.clock_polarity_select == $past(avl_req.writedata[ubg_pkg::BC_CKP_BIT])))
    else $error("baud control write not stored");

  // speed bit may toggle while in sync mode, the ratio must not follow it
  a_sync_ignores_hs: assert property (
    @(posedge clk) disable iff (!rst_n)
    (st_ff.cfg.sync_mode && $past(st_ff.cfg.sync_mode)) |-> $stable(pre_limit))
    else $error("speed bit changed the sync ratio");

  a_tick_counters_zero: assert property (
    @(posedge clk) disable iff (!rst_n)
    baud_tick |-> s_counters_clear)
    else $error("tick without both counters wrapped");

  a_restart_no_tick: assert property (
    @(posedge clk) disable iff (!rst_n)
    restart |=> !baud_tick)
    else $error("tick right after a divisor write");

  // shortest period is four cycles, so a tick never lasts two
  a_tick_single: assert property (
    @(posedge clk) disable iff (!rst_n)
    baud_tick |=> !baud_tick)
    else $error("tick wider than one cycle");

endmodule
`default_nettype wire

// ===== verification/ubg_baud_generator_tb.sv
// ubg_baud_generator_tb: self-checking bench of the baud rate generator
// assumes one 200 MHz clock and the one-wait-state avalon-mm slave
`timescale 1ns/1ps
`default_nettype none
module ubg_baud_generator_tb;

  logic                  clk;
  logic                  rst_n;
  ubg_pkg::ubg_avl_req_t avl_req;
  ubg_pkg::ubg_avl_rsp_t avl_rsp;
  logic                  baud_tick;
  ubg_pkg::ubg_cfg_t     cfg;
  int                    miscompares;
  int                    cmp_count;
  logic [31:0]           rd;

  ubg_baud_generator dut (
    .clk       (clk),
    .rst_n     (rst_n),
    .avl_req   (avl_req),
    .avl_rsp   (avl_rsp),
    .baud_tick (baud_tick),
    .cfg       (cfg)
  );

  always #2.5 clk = ~clk;

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic give_verdict();
    if (miscompares == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // request held until waitrequest is sampled low at a rising edge
  task automatic bus_write(input logic [7:0] addr, input logic [31:0] data,
                           input logic [3:0] be = 4'hf);
    int n;
    n = 0;
    @(posedge clk);
    avl_req.write      <= 1'b1;
    avl_req.address    <= addr;
    avl_req.writedata  <= data;
    avl_req.byteenable <= be;
    do begin
      @(posedge clk);
      n++;
    end while (avl_rsp.waitrequest !== 1'b0 && n < 20);
    if (n >= 20) begin
      miscompares++;
    end
    avl_req.write <= 1'b0;
  endtask

  task automatic bus_read(input logic [7:0] addr, output logic [31:0] data);
    int n;
    n = 0;
    @(posedge clk);
    avl_req.read    <= 1'b1;
    avl_req.address <= addr;
    do begin
      @(posedge clk);
      n++;
    end while (avl_rsp.waitrequest !== 1'b0 && n < 20);
    if (n >= 20) begin
      miscompares++;
    end
    data = avl_rsp.readdata;
    avl_req.read <= 1'b0;
  endtask

  // cycles from the current edge until baud_tick is seen high
  task automatic wait_tick(output int k);
    k = 0;
    do begin
      @(posedge clk);
      #1;
      k++;
    end while (baud_tick !== 1'b1 && k < 20000);
  endtask

  task automatic test_reset_values();
    bus_read(ubg_pkg::OFF_DIV_LOW, rd);
    check("div_low_rst", rd, {24'h000000, ubg_pkg::RST_DIV_LOW});
    bus_read(ubg_pkg::OFF_DIV_HIGH, rd);
    check("div_high_rst", rd, 32'h00000000);
    bus_read(ubg_pkg::OFF_TX_CTRL, rd);
    check("tx_ctrl_rst", rd, 32'h00000000);
    bus_read(ubg_pkg::OFF_BAUD_CTRL, rd);
    check("baud_ctrl_rst", rd, 32'h00000000);
    check("cfg_rst", {28'h0000000, cfg}, 32'h00000000);
    bus_read(8'h20, rd);
    check("unmapped_rd", rd, 32'h00000000);
  endtask

  task automatic test_register_bits();
    bus_write(ubg_pkg::OFF_DIV_HIGH, 32'hffffffff);
    bus_read(ubg_pkg::OFF_DIV_HIGH, rd);
    check("div_high_rw", rd, 32'h000000ff);
    bus_write(ubg_pkg::OFF_DIV_LOW, 32'h0000005a);
    bus_write(ubg_pkg::OFF_DIV_LOW, 32'h000000a5, 4'he);
    bus_read(ubg_pkg::OFF_DIV_LOW, rd);
    check("div_low_be", rd, 32'h0000005a);
    bus_write(ubg_pkg::OFF_TX_CTRL, 32'h000000ff);
    bus_read(ubg_pkg::OFF_TX_CTRL, rd);
    check("tx_ctrl_bits", rd, 32'h00000014);
    bus_write(ubg_pkg::OFF_BAUD_CTRL, 32'h000000ff);
    bus_read(ubg_pkg::OFF_BAUD_CTRL, rd);
    check("baud_ctrl_bits", rd, 32'h00000018);
    check("cfg_all_set", {28'h0000000, cfg}, 32'h0000000f);
    bus_write(ubg_pkg::OFF_TX_CTRL, 32'h00000004);
    bus_write(ubg_pkg::OFF_BAUD_CTRL, 32'h00000010);
    // the write lands at the edge the task returns on, look one edge later
    @(posedge clk);
    check("cfg_hs_ckp", {28'h0000000, cfg}, 32'h00000006);
  endtask

  // set mode and divisor, low byte last so that the period starts there
  task automatic run_mode(input string name, input logic [7:0] tx, input logic [7:0] bc,
                          input logic [7:0] hi, input logic [7:0] lo, input int p, input int n);
    int k;
    int exp;
    exp = p * (n + 1);
    bus_write(ubg_pkg::OFF_TX_CTRL, {24'h000000, tx});
    bus_write(ubg_pkg::OFF_BAUD_CTRL, {24'h000000, bc});
    bus_write(ubg_pkg::OFF_DIV_HIGH, {24'h000000, hi});
    bus_write(ubg_pkg::OFF_DIV_LOW, {24'h000000, lo});
    wait_tick(k);
    check({name, "_first"}, k, exp);
    wait_tick(k);
    check({name, "_period"}, k, exp);
  endtask

  task automatic test_modes();
    int p64;
    int p16;
    int p4;
    p64 = int'(ubg_pkg::PRE_LIM_64) + 1;
    p16 = int'(ubg_pkg::PRE_LIM_16) + 1;
    p4  = int'(ubg_pkg::PRE_LIM_4) + 1;
    // high byte 05 must not count while the divisor is narrow
    run_mode("async_narrow_lo", 8'h00, 8'h00, 8'h05, 8'h02, p64, 2);
    run_mode("async_narrow_hs", 8'h04, 8'h00, 8'h05, 8'h02, p16, 2);
    run_mode("async_wide_lo", 8'h00, 8'h08, 8'h01, 8'h02, p16, 258);
    run_mode("async_wide_hs", 8'h04, 8'h08, 8'h01, 8'h02, p4, 258);
    run_mode("sync_narrow", 8'h10, 8'h00, 8'h05, 8'h02, p4, 2);
    run_mode("sync_narrow_hs", 8'h14, 8'h10, 8'h05, 8'h02, p4, 2);
    run_mode("sync_wide", 8'h14, 8'h08, 8'h00, 8'h07, p4, 7);
  endtask

  // counter readout: one divisor step per four cycles in sync mode,
  // read request stands in cycle 14 after the tick, so three steps done
  task automatic test_count_read();
    run_mode("cnt_rd", 8'h10, 8'h08, 8'h00, 8'h07, int'(ubg_pkg::PRE_LIM_4) + 1, 7);
    repeat (13) @(posedge clk);
    bus_read(ubg_pkg::OFF_CNT_LOW, rd);
    check("cnt_low_rd", rd, 32'h00000003);
    bus_read(ubg_pkg::OFF_CNT_HIGH, rd);
    check("cnt_high_rd", rd, 32'h00000000);
  endtask

  // a high byte write mid-period restarts the count from that write
  task automatic test_high_restart();
    int k;
    bus_write(ubg_pkg::OFF_TX_CTRL, 32'h00000000);
    bus_write(ubg_pkg::OFF_BAUD_CTRL, 32'h00000000);
    bus_write(ubg_pkg::OFF_DIV_LOW, 32'h00000001);
    repeat (50) @(posedge clk);
    bus_write(ubg_pkg::OFF_DIV_HIGH, 32'h00000000);
    wait_tick(k);
    check("high_restart", k, 128);
    repeat (90) @(posedge clk);
    bus_write(ubg_pkg::OFF_DIV_LOW, 32'h00000001);
    wait_tick(k);
    check("low_restart", k, 128);
  endtask

  initial begin
    clk         = 1'b0;
    rst_n       = 1'b0;
    avl_req     = '0;
    miscompares = 0;
    cmp_count   = 0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    test_reset_values();
    test_register_bits();
    test_modes();
    test_count_read();
    test_high_restart();
    give_verdict();
  end

  // all tests take some 11600 cycles
  initial begin
    #300000;
    miscompares++;
    give_verdict();
  end

endmodule
`default_nettype wire
